// File: design/ctbo_edge_sync.sv
// two-flop synchroniser with edge detection for one pin
`default_nettype none

module ctbo_edge_sync (
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_n_i,
    // pin and result
    input wire logic pin_i,
    output ctbo_pkg::ctbo_edge_type edge_o
);

    logic meta_r;
    logic sync_r;
    logic last_r;

    // ---------------------------------------------------------------
    // synchroniser chain; first flop feeds only the second
    // ---------------------------------------------------------------
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
            last_r <= 1'b0;
        end else begin
            meta_r <= pin_i;
            sync_r <= meta_r;
            last_r <= sync_r;
        end
    end

    // level, rise and fall from consecutive samples, one driver for the whole struct
    assign edge_o = {sync_r, sync_r & ~last_r, ~sync_r & last_r};

endmodule // ctbo_edge_sync

`default_nettype wire

// File: design/ctbo_pkg.sv
// package: offsets, field layouts and codes for timer block one
`default_nettype none

package ctbo_pkg;

    // ---------------------------------------------------------------
    // register byte offsets
    // ---------------------------------------------------------------
    localparam logic [4:0] CORE_CTRL_OFS = 5'h00;
    localparam logic [4:0] CORE_TMR_OFS = 5'h04;
    localparam logic [4:0] AUXA_CTRL_OFS = 5'h08;
    localparam logic [4:0] AUXA_TMR_OFS = 5'h0C;
    localparam logic [4:0] AUXB_CTRL_OFS = 5'h10;
    localparam logic [4:0] AUXB_TMR_OFS = 5'h14;

    // ---------------------------------------------------------------
    // reset values and limits
    // ---------------------------------------------------------------
    localparam logic [15:0] TMR_RST = 16'h0000;
    localparam logic [15:0] TMR_MAX = 16'hFFFF;
    localparam logic [15:0] TMR_MIN = 16'h0000;
    localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;

    // ---------------------------------------------------------------
    // mode and edge codes
    // ---------------------------------------------------------------
    localparam logic [2:0] MODE_TIMER = 3'h0;
    localparam logic [2:0] MODE_COUNTER = 3'h1;
    localparam logic [2:0] MODE_GATE_LO = 3'h2;
    localparam logic [2:0] MODE_GATE_HI = 3'h3;
    localparam logic [2:0] EDGE_NONE = 3'h0;
    localparam logic [2:0] EDGE_RISE = 3'h1;
    localparam logic [2:0] EDGE_FALL = 3'h2;
    localparam logic [2:0] EDGE_BOTH = 3'h3;

    // ---------------------------------------------------------------
    // prescaler: divide by 8 * 2^sel, halved in fast mode
    // ---------------------------------------------------------------
    localparam int unsigned PRESC_BASE_LOG2 = 3;
    localparam int unsigned PRESC_W = 10;

    // core control register layout
    typedef struct packed {
        logic [3:0] rsvd;
        logic fast;
        logic latch;
        logic oe;
        logic ude;
        logic ud;
        logic run;
        logic [2:0] mode;
        logic [2:0] sel;
    } ctbo_core_ctrl_type;

    // auxiliary control register layout
    typedef struct packed {
        logic [6:0] rsvd;
        logic remote;
        logic ud;
        logic run;
        logic [2:0] mode;
        logic [2:0] sel;
    } ctbo_aux_ctrl_type;

    // synchronised pin with its edges
    typedef struct packed {
        logic level;
        logic rise;
        logic fall;
    } ctbo_edge_type;

endpackage : ctbo_pkg

`default_nettype wire

// File: design/ctbo_prescaler.sv
// programmable prescaler giving one-cycle count ticks
`default_nettype none

module ctbo_prescaler (
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_n_i,
    // setting
    input wire logic [2:0] sel_i,
    input wire logic fast_i,
    // tick
    output logic tick_o
);

    logic [ctbo_pkg::PRESC_W-1:0] cnt_r;
    logic [ctbo_pkg::PRESC_W:0] span;
    logic [ctbo_pkg::PRESC_W:0] mask;
    logic [3:0] shift;

    // period is 2^shift cycles
    assign shift = 4'(ctbo_pkg::PRESC_BASE_LOG2) + {1'b0, sel_i} - {3'h0, fast_i};
    assign span = (ctbo_pkg::PRESC_W + 1)'(1) << shift;
    assign mask = span - (ctbo_pkg::PRESC_W + 1)'(1);

    // free-running divider and tick
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_r <= '0;
            tick_o <= 1'b0;
        end else begin
            cnt_r <= cnt_r + 1'b1;
            tick_o <= ((cnt_r & mask[ctbo_pkg::PRESC_W-1:0]) ==
                       mask[ctbo_pkg::PRESC_W-1:0]);
        end
    end

endmodule // ctbo_prescaler

`default_nettype wire

// File: design/ctbo_timer_block.sv
// timer block one: core up/down timer and two auxiliary timers
//
// The address map and the Avalon-MM slave port were chosen for this implementation.
`default_nettype none

// Notes on behaviour
// - each timer is 16-bit, software readable/writable
// - software write beats same-cycle timer update
// - core counts only while run bit set
// - remote select lets core run drive auxiliary
// - direction from bit, or line xor bit
// - direction may change at any time
// - auxiliary direction set by software only
// - core wrap toggles the toggle latch
// - software may set or clear latch
// - latch reaches output line only when enabled
// - latch routed internally to auxiliary counters
// - timer mode ticks at clock/(8*2^sel), fast halves
// - gated modes share the timer-mode prescaler; each auxiliary timer has its own, using the core fast bit
// - gated modes count on low or high input
// - gated counting needs run bit and gate
// - gate transitions raise no interrupt
// - core counter mode counts input line edges; auxiliary counter mode counts toggle latch edges
// - sel picks none, rise, fall or both edges
module ctbo_timer_block (
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_n_i,
    // avalon-mm slave
    input wire logic [4:0] address_i,
    input wire logic read_i,
    input wire logic write_i,
    input wire logic [31:0] writedata_i,
    input wire logic [3:0] byteenable_i,
    output logic [31:0] readdata_o,
    output logic waitrequest_o,
    // external lines
    input wire logic core_input_line_i,
    input wire logic ext_direction_line_i,
    input wire logic [1:0] aux_input_line_i,
    output logic toggle_output_line_o
);

    // ---------------------------------------------------------------
    // declarations
    // ---------------------------------------------------------------
    ctbo_pkg::ctbo_core_ctrl_type core_ctrl_r;
    ctbo_pkg::ctbo_aux_ctrl_type aux_ctrl_r [2];
    logic [15:0] core_timer_r;
    logic [15:0] aux_timer_r [2];
    logic wrap_toggle_latch_r;
    logic latch_last_r;
    ctbo_pkg::ctbo_edge_type in_e;
    ctbo_pkg::ctbo_edge_type dir_e;
    ctbo_pkg::ctbo_edge_type aux_e [2];
    logic core_tick;
    logic [1:0] aux_tick;
    logic accept;
    logic wr_core_ctrl;
    logic wr_core_tmr;
    logic [1:0] wr_aux_ctrl;
    logic [1:0] wr_aux_tmr;
    logic [15:0] wr_val;
    logic core_down;
    logic core_step;
    logic core_wrap;
    logic latch_rise;
    logic latch_fall;
    logic [31:0] rd_mux;

    // merge the written low half with the old value per byte lane
    function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                            input logic [31:0] wd,
                                            input logic [3:0] be);
        logic [15:0] res;
        res = old_v;
        if (be[0]) begin
            res[7:0] = wd[7:0];
        end
        if (be[1]) begin
            res[15:8] = wd[15:8];
        end
        return res;
    endfunction

    // pick the selected edge of a signal
    function automatic logic edge_hit(input logic [2:0] sel,
                                      input logic rise,
                                      input logic fall);
        logic hit;
        hit = 1'b0;
        case (sel)
            ctbo_pkg::EDGE_RISE: hit = rise;
            ctbo_pkg::EDGE_FALL: hit = fall;
            ctbo_pkg::EDGE_BOTH: hit = rise | fall;
            default: hit = 1'b0; // none and reserved codes
        endcase
        return hit;
    endfunction

    // ---------------------------------------------------------------
    // pin synchronisers
    // ---------------------------------------------------------------
    // input and direction lines sampled through two flops
    ctbo_edge_sync u_in_sync (
        .clock_i (clock_i),
        .rst_n_i (rst_n_i),
        .pin_i (core_input_line_i),
        .edge_o (in_e)
    );

    ctbo_edge_sync u_dir_sync (
        .clock_i (clock_i),
        .rst_n_i (rst_n_i),
        .pin_i (ext_direction_line_i),
        .edge_o (dir_e)
    );

    // core prescaler
    ctbo_prescaler u_core_presc (
        .clock_i (clock_i),
        .rst_n_i (rst_n_i),
        .sel_i (core_ctrl_r.sel),
        .fast_i (core_ctrl_r.fast),
        .tick_o (core_tick)
    );

    // ---------------------------------------------------------------
    // avalon-mm slave
    // ---------------------------------------------------------------
    // one wait cycle, then the request is accepted
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            waitrequest_o <= 1'b1;
        end else if ((read_i | write_i) && waitrequest_o) begin
            waitrequest_o <= 1'b0;
        end else begin
            waitrequest_o <= 1'b1;
        end
    end

    // write strobes per register
    assign accept = write_i & ~waitrequest_o;
    assign wr_core_ctrl = accept && (address_i == ctbo_pkg::CORE_CTRL_OFS);
    assign wr_core_tmr = accept && (address_i == ctbo_pkg::CORE_TMR_OFS);
    assign wr_aux_ctrl[0] = accept && (address_i == ctbo_pkg::AUXA_CTRL_OFS);
    assign wr_aux_tmr[0] = accept && (address_i == ctbo_pkg::AUXA_TMR_OFS);
    assign wr_aux_ctrl[1] = accept && (address_i == ctbo_pkg::AUXB_CTRL_OFS);
    assign wr_aux_tmr[1] = accept && (address_i == ctbo_pkg::AUXB_TMR_OFS);

    // read mux; unmapped reads return zero
    always_comb begin
        ctbo_pkg::ctbo_core_ctrl_type cc;
        cc = core_ctrl_r;
        cc.latch = wrap_toggle_latch_r;
        case (address_i)
            ctbo_pkg::CORE_CTRL_OFS: rd_mux = {16'h0000, cc};
            ctbo_pkg::CORE_TMR_OFS: rd_mux = {16'h0000, core_timer_r};
            ctbo_pkg::AUXA_CTRL_OFS: rd_mux = {16'h0000, aux_ctrl_r[0]};
            ctbo_pkg::AUXA_TMR_OFS: rd_mux = {16'h0000, aux_timer_r[0]};
            ctbo_pkg::AUXB_CTRL_OFS: rd_mux = {16'h0000, aux_ctrl_r[1]};
            ctbo_pkg::AUXB_TMR_OFS: rd_mux = {16'h0000, aux_timer_r[1]};
            default: rd_mux = ctbo_pkg::RD_UNMAPPED;
        endcase
    end

    // read data registered as waitrequest drops
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            readdata_o <= 32'h0000_0000;
        end else if (read_i && waitrequest_o) begin
            readdata_o <= rd_mux;
        end
    end

    // ---------------------------------------------------------------
    // core control register
    // ---------------------------------------------------------------
    // reserved bits and the latch bit are not stored here
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            core_ctrl_r <= '0;
        end else if (wr_core_ctrl) begin
            core_ctrl_r <= merge16(core_ctrl_r, writedata_i, byteenable_i);
            core_ctrl_r.rsvd <= 4'h0;
            core_ctrl_r.latch <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // core timer
    // ---------------------------------------------------------------
    // direction: bit alone, or external line xor bit
    assign core_down = core_ctrl_r.ude ? (dir_e.level ^ core_ctrl_r.ud)
                                       : core_ctrl_r.ud;

    // count enable per mode; no interrupt output exists at all
    always_comb begin
        case (core_ctrl_r.mode)
            ctbo_pkg::MODE_TIMER: core_step = core_tick;
            ctbo_pkg::MODE_GATE_LO,
            ctbo_pkg::MODE_GATE_HI:
                core_step = core_tick &
                            (in_e.level == core_ctrl_r.mode[0]);
            ctbo_pkg::MODE_COUNTER:
                core_step = edge_hit(core_ctrl_r.sel, in_e.rise,
                                     in_e.fall);
            default: core_step = 1'b0;
        endcase
        core_step = core_step & core_ctrl_r.run;
    end

    // wrap at the end of the range in the current direction
    assign core_wrap = core_step & (core_down ? (core_timer_r == ctbo_pkg::TMR_MIN)
                                              : (core_timer_r == ctbo_pkg::TMR_MAX));
    assign wr_val = merge16(core_timer_r, writedata_i, byteenable_i);

    // software write has priority over counting
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            core_timer_r <= ctbo_pkg::TMR_RST;
        end else if (wr_core_tmr) begin
            core_timer_r <= wr_val;
        end else if (core_step) begin
            core_timer_r <= core_down ? core_timer_r - 16'h0001
                                      : core_timer_r + 16'h0001;
        end
    end

    // ---------------------------------------------------------------
    // toggle latch and output line
    // ---------------------------------------------------------------
    // toggled by wrap, set or cleared by software write
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wrap_toggle_latch_r <= 1'b0;
        end else if (wr_core_ctrl && byteenable_i[1]) begin
            wrap_toggle_latch_r <= writedata_i[10];
        end else if (core_wrap) begin
            wrap_toggle_latch_r <= ~wrap_toggle_latch_r;
        end
    end

    // latch history for internal edge use, and gated output
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            latch_last_r <= 1'b0;
            toggle_output_line_o <= 1'b0;
        end else begin
            latch_last_r <= wrap_toggle_latch_r;
            toggle_output_line_o <= wrap_toggle_latch_r & core_ctrl_r.oe;
        end
    end

    assign latch_rise = wrap_toggle_latch_r & ~latch_last_r;
    assign latch_fall = ~wrap_toggle_latch_r & latch_last_r;

    // ---------------------------------------------------------------
    // auxiliary timers
    // ---------------------------------------------------------------
    for (genvar i = 0; i < 2; i++) begin : g_aux
        logic run;
        logic step;

        ctbo_edge_sync u_aux_sync (
            .clock_i (clock_i),
            .rst_n_i (rst_n_i),
            .pin_i (aux_input_line_i[i]),
            .edge_o (aux_e[i])
        );

        ctbo_prescaler u_aux_presc (
            .clock_i (clock_i),
            .rst_n_i (rst_n_i),
            .sel_i (aux_ctrl_r[i].sel),
            .fast_i (core_ctrl_r.fast),
            .tick_o (aux_tick[i])
        );

        // own run bit, or the core run bit when remote
        assign run = aux_ctrl_r[i].remote ? core_ctrl_r.run
                                          : aux_ctrl_r[i].run;

        // count enable; counter mode counts toggle latch edges
        always_comb begin
            case (aux_ctrl_r[i].mode)
                ctbo_pkg::MODE_TIMER: step = aux_tick[i];
                ctbo_pkg::MODE_GATE_LO,
                ctbo_pkg::MODE_GATE_HI:
                    step = aux_tick[i] &
                           (aux_e[i].level == aux_ctrl_r[i].mode[0]);
                ctbo_pkg::MODE_COUNTER:
                    step = edge_hit(aux_ctrl_r[i].sel, latch_rise,
                                    latch_fall);
                default: step = 1'b0;
            endcase
            step = step & run;
        end

        // control register, reserved bits kept zero
        always_ff @(posedge clock_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
                aux_ctrl_r[i] <= '0;
            end else if (wr_aux_ctrl[i]) begin
                aux_ctrl_r[i] <= merge16(aux_ctrl_r[i], writedata_i, byteenable_i);
                aux_ctrl_r[i].rsvd <= 7'h00;
            end
        end

        // timer; direction from software bit only
        always_ff @(posedge clock_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
                aux_timer_r[i] <= ctbo_pkg::TMR_RST;
            end else if (wr_aux_tmr[i]) begin
                aux_timer_r[i] <= merge16(aux_timer_r[i], writedata_i,
                                          byteenable_i);
            end else if (step) begin
                aux_timer_r[i] <= aux_ctrl_r[i].ud ? aux_timer_r[i] - 16'h0001
                                                   : aux_timer_r[i] + 16'h0001;
            end
        end
    end

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    bus_answer_a: assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        ((read_i | write_i) && waitrequest_o) |=> !waitrequest_o ##1 waitrequest_o)
        else $error("bus answer not after one wait cycle");

    write_prio_a: assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        wr_core_tmr |=> core_timer_r == $past(wr_val))
        else $error("software write lost to timer update");

    run_halt_a: assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        (!core_ctrl_r.run && !wr_core_tmr) |=> $stable(core_timer_r))
        else $error("core timer moved while halted");

    remote_run_a: assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        (aux_ctrl_r[0].remote && !core_ctrl_r.run && !wr_aux_tmr[0])
        |=> $stable(aux_timer_r[0]))
        else $error("remote auxiliary timer ran without core run");

    down_count_a: assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        (core_step && core_down && !wr_core_tmr)
        |=> core_timer_r == $past(core_timer_r) - 16'h0001)
        else $error("core timer did not count down");

    wrap_toggle_a: assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        (core_wrap && !wr_core_ctrl) |=> wrap_toggle_latch_r != $past(wrap_toggle_latch_r))
        else $error("wrap did not toggle latch");

    out_enable_a: assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        (!core_ctrl_r.oe) |=> !toggle_output_line_o)
        else $error("toggle output driven while disabled");

    presc_gap_a: assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        (core_tick && $stable(core_ctrl_r)) |=> !core_tick [*3])
        else $error("prescaler ticks closer than four cycles");

    gate_stop_a: assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        (core_ctrl_r.mode == ctbo_pkg::MODE_GATE_HI && !in_e.level && !wr_core_tmr)
        |=> $stable(core_timer_r))
        else $error("gated timer moved with gate inactive");

    edge_none_a: assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        (core_ctrl_r.mode == ctbo_pkg::MODE_COUNTER &&
         core_ctrl_r.sel == ctbo_pkg::EDGE_NONE && !wr_core_tmr)
        |=> $stable(core_timer_r))
        else $error("counter moved with no edge selected");

endmodule // ctbo_timer_block

`default_nettype wire

// File: sim/ctbo_line_model.sv
// partner model: external count, gate and direction lines
`default_nettype none
module ctbo_line_model (
    // clock
    input wire logic clock_i,
    // lines toward the timer block
    output logic count_line_o,
    output logic dir_line_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // both lines idle low at time zero
    initial begin
        count_line_o = 1'b0;
        dir_line_o = 1'b0;
    end
    // set gate or count level and direction level
    task automatic drive(input logic cnt, input logic dir);
        @(posedge clock_i);
        count_line_o <= cnt;
        dir_line_o <= dir;
    endtask
    // count pulses, each level held four cycles, then settle
    task automatic pulse(input int n);
        repeat (n) begin
            @(posedge clock_i);
            count_line_o <= 1'b1;
            repeat (4) @(posedge clock_i);
            count_line_o <= 1'b0;
            repeat (3) @(posedge clock_i);
        end
        repeat (4) @(posedge clock_i);
    endtask
endmodule // ctbo_line_model
`default_nettype wire

// File: sim/tb_ctbo_timer_block.sv
// self-checking bench for timer block one
`default_nettype none
module tb_ctbo_timer_block;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [4:0] CC_A = ctbo_pkg::CORE_CTRL_OFS;
    localparam logic [4:0] CT_A = ctbo_pkg::CORE_TMR_OFS;
    localparam logic [4:0] AC_A = ctbo_pkg::AUXA_CTRL_OFS;
    localparam logic [4:0] AT_A = ctbo_pkg::AUXA_TMR_OFS;
    logic clock_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [4:0] address_i = 5'h00;
    logic read_i = 1'b0;
    logic write_i = 1'b0;
    logic [31:0] writedata_i = 32'h0000_0000;
    logic [31:0] readdata_o;
    logic waitrequest_o;
    logic cnt_line;
    logic dir_line;
    logic toggle_output_line_o;
    logic [31:0] rdata;
    int fail_count = 0;
    int samples_checked = 0;
    int k;
    // {ude, ud, line, down}
    logic [3:0] dir_tab [6] = '{4'h2, 4'h5, 4'h8, 4'hB, 4'hD, 4'hE};
    // 100 MHz clock
    always #5 clock_i = ~clock_i;
    ctbo_timer_block uut (.clock_i(clock_i), .rst_n_i(rst_n_i), .address_i(address_i),
        .read_i(read_i), .write_i(write_i), .writedata_i(writedata_i), .byteenable_i(4'h3),
        .readdata_o(readdata_o), .waitrequest_o(waitrequest_o), .core_input_line_i(cnt_line),
        .ext_direction_line_i(dir_line), .aux_input_line_i(2'b00),
        .toggle_output_line_o(toggle_output_line_o));
    ctbo_line_model pm (.clock_i(clock_i), .count_line_o(cnt_line), .dir_line_o(dir_line));
    // compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // one avalon cycle, held until waitrequest is low
    task automatic bus(input logic wr, input logic [4:0] a, input logic [15:0] d);
        @(posedge clock_i);
        address_i <= a;
        writedata_i <= {16'h0000, d};
        read_i <= ~wr;
        write_i <= wr;
        // no limit here: only the watchdog ends a hung wait
        do begin
            @(posedge clock_i);
        end while (waitrequest_o !== 1'b0);
        rdata = readdata_o;
        read_i <= 1'b0;
        write_i <= 1'b0;
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rd(input logic [4:0] a);
        bus(1'b0, a, 16'h0000);
    endtask
    // core ctrl word, h = {fast, latch, oe, ude, ud, run}
    function automatic logic [15:0] cc(logic [2:0] s, logic [2:0] m, logic [5:0] h);
        return {4'h0, h, m, s};
    endfunction
    task automatic s_reset();
        rd(CC_A);
        check(rdata, 32'h0);
        wr(CT_A, 16'hA5C3);
        rd(CT_A);
        check(rdata, 32'h0000_A5C3);
        rd(5'h18);
        check(rdata, ctbo_pkg::RD_UNMAPPED);
    endtask
    task automatic s_rate(input logic [2:0] s, input logic f, input int lo);
        logic [31:0] v;
        wr(CT_A, 16'h0000);
        wr(CC_A, cc(s, 3'h0, {f, 5'h01}));
        repeat (64) @(posedge clock_i);
        wr(CC_A, cc(s, 3'h0, {f, 5'h00}));
        rd(CT_A);
        v = rdata;
        check({31'h0, v >= lo && v <= lo + 3}, 32'h1);
        repeat (40) @(posedge clock_i);
        rd(CT_A);
        check(rdata, v);
    endtask
    task automatic s_gate(input logic [2:0] m);
        pm.drive(~m[0], 1'b0);
        wr(CC_A, cc(3'h0, m, 6'h21));
        // cleared after the mode change: a line edge may still count in counter mode
        wr(CT_A, 16'h0000);
        repeat (40) @(posedge clock_i);
        rd(CT_A);
        check(rdata, 32'h0);
        pm.drive(m[0], 1'b0);
        repeat (40) @(posedge clock_i);
        wr(CC_A, cc(3'h0, m, 6'h20));
        rd(CT_A);
        check({31'h0, rdata > 32'h8}, 32'h1);
    endtask
    task automatic s_count(logic [15:0] c, logic [15:0] t, logic d, logic [15:0] e);
        pm.drive(1'b0, d);
        wr(CT_A, t);
        wr(CC_A, c);
        pm.pulse(1);
        rd(CT_A);
        check(rdata, {16'h0, e});
    endtask
    task automatic s_wrap();
        wr(AT_A, 16'h0000);
        wr(AC_A, 16'h004B); // aux a counts both latch edges
        s_count(cc(3'h1, 3'h1, 6'h01), 16'hFFFF, 1'b0, 16'h0000);
        rd(CC_A);
        check(rdata, 32'h0000_0449);
        check({31'h0, toggle_output_line_o}, 32'h0);
        wr(CC_A, 16'h0600);
        repeat (2) @(posedge clock_i);
        check({31'h0, toggle_output_line_o}, 32'h1);
        wr(CC_A, 16'h0200);
        repeat (2) @(posedge clock_i);
        check({31'h0, toggle_output_line_o}, 32'h0);
        wr(CC_A, 16'h0600);
        repeat (2) @(posedge clock_i);
        check({31'h0, toggle_output_line_o}, 32'h1);
        s_count(cc(3'h1, 3'h1, 6'h0B), 16'h0000, 1'b0, 16'hFFFF);
        check({31'h0, toggle_output_line_o}, 32'h1);
        // five latch transitions since aux a was armed
        rd(AT_A);
        check(rdata, 32'h0000_0005);
    endtask
    task automatic s_remote();
        logic [31:0] v;
        wr(AT_A, 16'h0000);
        wr(AC_A, 16'h0100);
        wr(CC_A, cc(3'h0, 3'h0, 6'h21));
        repeat (40) @(posedge clock_i);
        wr(CC_A, 16'h0000);
        rd(AT_A);
        v = rdata;
        check({31'h0, v > 32'h8}, 32'h1);
        repeat (40) @(posedge clock_i);
        rd(AT_A);
        check(rdata, v);
    endtask
    // main sequence
    initial begin
        repeat (8) @(posedge clock_i);
        rst_n_i <= 1'b1;
        s_reset();
        s_rate(3'h0, 1'b0, 7);
        s_rate(3'h0, 1'b1, 15);
        s_rate(3'h1, 1'b0, 3);
        for (k = 0; k < 4; k++) begin // only sel codes 000 to 011
            s_count(cc(k[2:0], 3'h1, 6'h01), 16'h0010, 1'b0, 16'h0010 + 16'((k + 1) / 2));
        end
        for (k = 0; k < 6; k++) begin
            s_count(cc(3'h3, 3'h1, {3'b000, dir_tab[k][3:2], 1'b1}), 16'h0010,
                dir_tab[k][1], dir_tab[k][0] ? 16'h000E : 16'h0012);
        end
        s_gate(3'h2);
        s_gate(3'h3);
        s_wrap();
        s_remote();
        end_of_test();
    end
    // watchdog
    initial begin
        repeat (20000) @(posedge clock_i);
        fail_count++;
        end_of_test();
    end
endmodule // tb_ctbo_timer_block
`default_nettype wire
